/* File: ejector_pkg.sv */
package ejector_pkg;
	localparam int VAC_W = 10;
	localparam int REF_CLK_HZ = 200_000_000;
	localparam int MS_PER_S = 1000;
	localparam int MS_CYCLES = REF_CLK_HZ / MS_PER_S;
	localparam int IMP_MIN_PULSE_MS = 50;
	localparam int IMP_MIN_CYCLES = REF_CLK_HZ / MS_PER_S * IMP_MIN_PULSE_MS;
	localparam int FLASH_HALF_MS = 250;
	localparam int FLASH_W = $clog2(FLASH_HALF_MS);
	localparam logic [FLASH_W-1:0] FLASH_LAST = FLASH_W'(FLASH_HALF_MS - 1);

	localparam logic [3:0] OFS_CFG = 4'h0;
	localparam logic [3:0] OFS_OFF = 4'h4;
	localparam logic [3:0] OFS_PRES = 4'h8;
	localparam logic [3:0] OFS_STAT = 4'hC;

	// Input slots: two controller pins, then four buttons
	localparam int NUM_PIN = 2;
	localparam int NUM_IN = 6;
	localparam int IN_SUCK = 0;
	localparam int IN_BLOW = 1;
	localparam int BTN_ON = 2;
	localparam int BTN_OFF = 3;
	localparam int BTN_BLOW = 4;
	localparam int BTN_STOP = 5;

	typedef enum logic [1:0] {VAR_NO = 2'b00, VAR_NC = 2'b01, VAR_IMP = 2'b10} variant_type;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SUCK = 2'b01, ST_BLOW = 2'b10} state_type;
	typedef enum logic [1:0] {LVL_LOW = 2'b00, LVL_MID = 2'b01, LVL_HIGH = 2'b10} level_type;

	// Field layout is the register layout, low bit last
	typedef struct packed {
		logic [VAC_W-1:0] blowMs;
		logic manual;
		logic npn;
		logic airSave;
		logic autoBlow;
		variant_type variant;
	} cfg_type;
	localparam int CFG_W = $bits(cfg_type);

	typedef struct packed {
		logic [VAC_W-1:0] hyst;
		logic [VAC_W-1:0] point;
	} point_type;
	localparam int PT_W = $bits(point_type);

	typedef struct packed {
		level_type level;
		state_type state;
		logic [VAC_W-1:0] vacuum;
	} status_type;
	localparam int STAT_W = $bits(status_type);

	typedef struct packed {
		logic suctionLed;
		logic blowLed;
		logic limitOffLed;
		logic limitPresentLed;
		logic statusRed;
		logic statusGreen;
		logic blowDisplay;
	} ind_type;

	localparam cfg_type CFG_RST = '{blowMs: 10'h0C8, manual: 1'b0, npn: 1'b0, airSave: 1'b0,
		autoBlow: 1'b1, variant: VAR_NC};
	localparam point_type OFF_RST = '{hyst: 10'h096, point: 10'h2EE};
	localparam point_type PRES_RST = '{hyst: 10'h00A, point: 10'h226};
endpackage : ejector_pkg

/* File: input_qualifier.sv */
`timescale 1ns/100ps
`default_nettype none
module input_qualifier #(
	parameter int MIN_CYCLES = 1
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic pinRaw,
	input wire logic invert,
	output logic active,
	output logic fire
);
	import ejector_pkg::*;
	localparam int CW = $clog2(MIN_CYCLES + 1);
	localparam logic [CW-1:0] CNT_MAX = CW'(MIN_CYCLES);
	logic meta_q, meta_d, sync_q, sync_d;
	logic [CW-1:0] cnt_q, cnt_d;

	assign active = sync_q ^ invert;
	// One pulse per assertion held MIN_CYCLES cycles or more, so a held input never fires twice
	assign fire = active && (cnt_q == CNT_MAX - 1'b1);

	always_comb begin
		meta_d = pinRaw;
		sync_d = meta_q;
		cnt_d = cnt_q;
		if (!active) begin
			cnt_d = '0;
		end else if (cnt_q != CNT_MAX) begin
			cnt_d = cnt_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			cnt_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			cnt_q <= cnt_d;
		end
	end
endmodule : input_qualifier
`default_nettype wire

/* File: level_compare.sv */
`timescale 1ns/100ps
`default_nettype none
module level_compare (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [ejector_pkg::VAC_W-1:0] vacuum,
	input wire ejector_pkg::point_type offPt,
	input wire ejector_pkg::point_type presPt,
	output ejector_pkg::level_type level
);
	import ejector_pkg::*;
	level_type level_q, level_d;
	logic [VAC_W-1:0] offThr, presThr;

	// Saturates so a hysteresis larger than its point cannot wrap
	function automatic logic [VAC_W-1:0] lowered(input point_type p);
		return (p.hyst > p.point) ? '0 : p.point - p.hyst;
	endfunction : lowered

	assign level = level_q;

	always_comb begin
		offThr = (level_q == LVL_HIGH) ? lowered(offPt) : offPt.point;
		presThr = (level_q != LVL_LOW) ? lowered(presPt) : presPt.point;
		if (vacuum > offThr) begin
			level_d = LVL_HIGH;
		end else if (vacuum > presThr) begin
			level_d = LVL_MID;
		end else begin
			level_d = LVL_LOW;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			level_q <= LVL_LOW;
		end else begin
			level_q <= level_d;
		end
	end
endmodule : level_compare
`default_nettype wire

/* File: vacuum_ejector_control_status.sv */
`timescale 1ns/100ps
`default_nettype none
module vacuum_ejector_control_status #(
	parameter int MS_CYCLES_P = ejector_pkg::MS_CYCLES,
	parameter int IMP_MIN_CYCLES_P = ejector_pkg::IMP_MIN_CYCLES
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdata,
	input wire logic suctionPin,
	input wire logic blowPin,
	input wire logic [3:0] buttonPin,
	input wire logic [ejector_pkg::VAC_W-1:0] vacuum,
	output logic nozzleOn,
	output logic blowValve,
	output logic pressureSwitchOut,
	output ejector_pkg::ind_type indicators
);
	import ejector_pkg::*;
	localparam int MSW = $clog2(MS_CYCLES_P + 1);
	localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYCLES_P - 1);

	cfg_type cfg_q, cfg_d;
	point_type offPt_q, offPt_d, presPt_q, presPt_d;
	status_type stat;
	logic [31:0] rdata_q, rdata_d;
	logic [NUM_IN-1:0] pinVec, inActive, inFire;
	level_type level;
	state_type state_q, state_d;
	logic timed_q, timed_d, stale_q, stale_d, manSuck_q, manSuck_d;
	logic [VAC_W-1:0] blowCnt_q, blowCnt_d;
	logic isImp, isNo, autoOk, suckWant, blowWant, suckStart;
	logic [MSW-1:0] msCnt_q, msCnt_d;
	logic msTick;
	logic [FLASH_W-1:0] flashCnt_q, flashCnt_d;
	logic flash_q, flash_d;
	ind_type ind_q, ind_d;
	logic nozzle_q, nozzle_d, blowV_q, blowV_d, psw_q, psw_d;

	assign regRdata = rdata_q;
	assign indicators = ind_q;
	assign nozzleOn = nozzle_q;
	assign blowValve = blowV_q;
	assign pressureSwitchOut = psw_q;

	// Controller pins follow the stored polarity, buttons do not
	assign pinVec = {buttonPin, blowPin, suctionPin};
	for (genvar gi = 0; gi < NUM_IN; gi++) begin : g_in
		input_qualifier #(
			.MIN_CYCLES(gi == IN_SUCK ? IMP_MIN_CYCLES_P : 1)
		) u_qual (
			.ref_clk(ref_clk),
			.nrst(nrst),
			.pinRaw(pinVec[gi]),
			.invert(gi < NUM_PIN ? cfg_q.npn : 1'b0),
			.active(inActive[gi]),
			.fire(inFire[gi])
		);
	end

	level_compare u_level (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.vacuum(vacuum),
		.offPt(offPt_q),
		.presPt(presPt_q),
		.level(level)
	);

	// Register port
	always_comb begin
		cfg_d = cfg_q;
		offPt_d = offPt_q;
		presPt_d = presPt_q;
		rdata_d = '0;
		stat = '{level: level, state: state_q, vacuum: vacuum};
		if (regWrite) begin
			case (regAddr)
				OFS_CFG: cfg_d = cfg_type'(regWdata[CFG_W-1:0]);
				OFS_OFF: offPt_d = point_type'(regWdata[PT_W-1:0]);
				OFS_PRES: presPt_d = point_type'(regWdata[PT_W-1:0]);
				default: ;
			endcase
		end
		if (regRead) begin
			case (regAddr)
				OFS_CFG: rdata_d = 32'(cfg_q);
				OFS_OFF: rdata_d = 32'(offPt_q);
				OFS_PRES: rdata_d = 32'(presPt_q);
				OFS_STAT: rdata_d = 32'(stat);
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			cfg_q <= CFG_RST;
			offPt_q <= OFF_RST;
			presPt_q <= PRES_RST;
			rdata_q <= '0;
		end else begin
			cfg_q <= cfg_d;
			offPt_q <= offPt_d;
			presPt_q <= presPt_d;
			rdata_q <= rdata_d;
		end
	end

	// Millisecond tick and flash phase
	always_comb begin
		msTick = (msCnt_q == MS_LAST);
		msCnt_d = msTick ? '0 : msCnt_q + 1'b1;
		flashCnt_d = flashCnt_q;
		flash_d = flash_q;
		if (msTick) begin
			flashCnt_d = (flashCnt_q == FLASH_LAST) ? '0 : flashCnt_q + 1'b1;
			flash_d = (flashCnt_q == FLASH_LAST) ? !flash_q : flash_q;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			msCnt_q <= '0;
			flashCnt_q <= '0;
			flash_q <= 1'b0;
		end else begin
			msCnt_q <= msCnt_d;
			flashCnt_q <= flashCnt_d;
			flash_q <= flash_d;
		end
	end

	// Ejector sequencing
	always_comb begin
		isImp = (cfg_q.variant == VAR_IMP);
		isNo = (cfg_q.variant == VAR_NO);
		autoOk = cfg_q.autoBlow && !isImp;
		manSuck_d = manSuck_q;
		if (inFire[BTN_ON]) begin
			manSuck_d = 1'b1;
		end
		if (inFire[BTN_OFF] || inFire[BTN_STOP] || !cfg_q.manual) begin
			manSuck_d = 1'b0;
		end
		if (cfg_q.manual) begin
			suckWant = manSuck_q;
			blowWant = inActive[BTN_BLOW];
			suckStart = manSuck_q;
		end else begin
			suckWant = isNo ? !inActive[IN_SUCK] : inActive[IN_SUCK];
			blowWant = inActive[IN_BLOW];
			suckStart = isImp ? (inFire[IN_SUCK] && !stale_q) : suckWant;
		end
		// A suction level seen during blow-off stays stale until it drops
		stale_d = (state_q == ST_BLOW) || (stale_q && inActive[IN_SUCK]);
		state_d = state_q;
		timed_d = timed_q;
		blowCnt_d = blowCnt_q;
		unique case (state_q)
			ST_IDLE: begin
				if (blowWant) begin
					state_d = ST_BLOW;
					timed_d = 1'b0;
				end else if (suckStart) begin
					state_d = ST_SUCK;
				end
			end
			ST_SUCK: begin
				if (blowWant) begin
					state_d = ST_BLOW;
					timed_d = 1'b0;
				end else if ((!isImp || cfg_q.manual) && !suckWant) begin
					state_d = autoOk ? ST_BLOW : ST_IDLE;
					timed_d = autoOk;
					blowCnt_d = '0;
				end
			end
			ST_BLOW: begin
				if (blowWant) begin
					timed_d = 1'b0;
				end else if (!timed_q || blowCnt_q >= cfg_q.blowMs) begin
					state_d = ST_IDLE;
				end else if (msTick) begin
					blowCnt_d = blowCnt_q + 1'b1;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
			timed_q <= 1'b0;
			stale_q <= 1'b0;
			manSuck_q <= 1'b0;
			blowCnt_q <= '0;
		end else begin
			state_q <= state_d;
			timed_q <= timed_d;
			stale_q <= stale_d;
			manSuck_q <= manSuck_d;
			blowCnt_q <= blowCnt_d;
		end
	end

	// Valves, switch output and indicators
	always_comb begin
		nozzle_d = (state_q == ST_SUCK) && !(cfg_q.airSave && level == LVL_HIGH);
		blowV_d = (state_q == ST_BLOW);
		psw_d = (level == LVL_HIGH) ^ cfg_q.npn;
		ind_d = '0;
		ind_d.blowDisplay = (state_q == ST_BLOW);
		ind_d.blowLed = (state_q == ST_BLOW);
		if (isNo) begin
			ind_d.suctionLed = (state_q != ST_SUCK);
		end else begin
			ind_d.suctionLed = (state_q == ST_SUCK);
		end
		// Only a running suction cycle lights the status display
		if (state_q == ST_SUCK) begin
			ind_d.statusRed = (level == LVL_LOW) || (level == LVL_MID && flash_q);
			ind_d.statusGreen = (level == LVL_HIGH);
		end
		ind_d.limitOffLed = (level == LVL_HIGH);
		ind_d.limitPresentLed = (level != LVL_LOW);
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			nozzle_q <= 1'b0;
			blowV_q <= 1'b0;
			psw_q <= 1'b0;
			ind_q <= '0;
		end else begin
			nozzle_q <= nozzle_d;
			blowV_q <= blowV_d;
			psw_q <= psw_d;
			ind_q <= ind_d;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	chk_ext_blow_entry: assert property (
		!cfg_q.manual && inActive[IN_BLOW] |=> state_q == ST_BLOW
	) else $error("external blow-off not entered");

	chk_auto_blow_start: assert property (
		state_q == ST_SUCK && state_d != ST_SUCK && autoOk && !blowWant |=> state_q == ST_BLOW && timed_q
	) else $error("automatic blow-off did not start");

	chk_auto_blow_end: assert property (
		state_q == ST_BLOW && timed_q && !blowWant && blowCnt_q >= cfg_q.blowMs |=> state_q == ST_IDLE
	) else $error("automatic blow-off did not end on time");

	chk_imp_no_auto: assert property (
		isImp && !cfg_q.manual && state_q == ST_SUCK && !inActive[IN_BLOW] |=> state_q == ST_SUCK
	) else $error("pulse-latched suction left without blow-off");

	chk_imp_fresh_pulse: assert property (
		isImp && !cfg_q.manual && stale_q && state_q == ST_IDLE && !inActive[IN_BLOW] |=> state_q == ST_IDLE
	) else $error("stale suction input restarted suction");

	chk_blow_display: assert property (
		indicators.blowDisplay == ($past(state_q) == ST_BLOW)
	) else $error("blow-off indication wrong");

	chk_polarity_reset: assert property (
		$rose(nrst) |-> !cfg_q.npn && !cfg_q.manual
	) else $error("polarity not source switching after reset");

	chk_open_leds: assert property (
		isNo && state_q == ST_SUCK |=> !indicators.suctionLed && !indicators.blowLed
	) else $error("open-at-rest valve LEDs wrong in suction");

	chk_closed_leds: assert property (
		!isNo && state_q == ST_BLOW |=> !indicators.suctionLed && indicators.blowLed
	) else $error("blow LED alone expected in blow-off");

	chk_status_flash: assert property (
		state_q == ST_SUCK && level == LVL_MID |=> indicators.statusRed == $past(flash_q) && !indicators.statusGreen
	) else $error("status display not flashing red");

	chk_status_green: assert property (
		state_q == ST_SUCK && level == LVL_HIGH |=> indicators.statusGreen && !indicators.statusRed
	) else $error("status display not green");

	chk_status_dark: assert property (
		state_q != ST_SUCK |=> !indicators.statusRed && !indicators.statusGreen
	) else $error("status display lit outside suction");

	chk_limit_leds: assert property (
		indicators.limitOffLed == ($past(level) == LVL_HIGH) && indicators.limitPresentLed == ($past(level) != LVL_LOW)
	) else $error("limit LEDs do not follow level");

	chk_air_saving: assert property (
		state_q == ST_SUCK && cfg_q.airSave && level == LVL_HIGH |=> !nozzleOn
	) else $error("nozzle not off at suction-off point");

	cov_auto_blow: cover property (state_q == ST_BLOW && timed_q ##1 state_q == ST_IDLE);
	cov_imp_suck: cover property (isImp && state_q == ST_IDLE ##1 state_q == ST_SUCK);
	cov_green: cover property (indicators.statusGreen);
	cov_flash: cover property (state_q == ST_SUCK && level == LVL_MID && flash_q);
endmodule : vacuum_ejector_control_status
`default_nettype wire

/* File: controller_model.sv */
`timescale 1ns/100ps
`default_nettype none
module controller_model (
	input wire logic ref_clk,
	input wire logic npn,
	input wire logic suckCmd,
	input wire logic blowCmd,
	output logic suctionPin,
	output logic blowPin
);
	initial begin
		suctionPin = 1'b0;
		blowPin = 1'b0;
	end
	// Sinking outputs idle high, so the asserted level flips with the polarity setting
	always @(posedge ref_clk) begin
		suctionPin <= suckCmd ^ npn;
		blowPin <= blowCmd ^ npn;
	end
endmodule : controller_model
`default_nettype wire

/* File: vacuum_ejector_control_status_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
	$display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (b)); end end
module vacuum_ejector_control_status_tb;
	import ejector_pkg::*;
	localparam int MSC = 4;
	localparam int LIMIT = 20000;
	logic ref_clk, nrst, regWrite, regRead, suctionPin, blowPin, nozzleOn, blowValve, pressureSwitchOut;
	logic suckCmd, blowCmd, npnSet, redSeen;
	logic [3:0] regAddr, buttonPin;
	logic [31:0] regWdata, regRdata, rdv;
	logic [VAC_W-1:0] vacuum;
	ind_type indicators;
	level_type curLvl;
	int fails, check_count, cycles;
	logic [VAC_W-1:0] corners [9] = '{10'h226, 10'h227, 10'h2EE, 10'h2EF, 10'h259, 10'h258, 10'h21D, 10'h21C, 10'h300};

	vacuum_ejector_control_status #(.MS_CYCLES_P(MSC), .IMP_MIN_CYCLES_P(8)) vacuum_ejector_control_status_inst (
		.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
		.regRead(regRead), .regRdata(regRdata), .suctionPin(suctionPin), .blowPin(blowPin),
		.buttonPin(buttonPin), .vacuum(vacuum), .nozzleOn(nozzleOn), .blowValve(blowValve),
		.pressureSwitchOut(pressureSwitchOut), .indicators(indicators));
	controller_model controller_model_inst (.ref_clk(ref_clk), .npn(npnSet), .suckCmd(suckCmd),
		.blowCmd(blowCmd), .suctionPin(suctionPin), .blowPin(blowPin));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic print_verdict;
		$display("checks=%0d fails=%0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : print_verdict

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			fails++;
			print_verdict();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge ref_clk);
		regWrite <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1 rdv = regRdata;
	endtask : rd

	// Waits long enough for the pin synchronisers to settle under the new polarity
	task automatic setCfg(input logic [1:0] v, input logic ab, input logic as, input logic np, input logic man);
		npnSet <= np;
		wr(OFS_CFG, {16'h0, 10'h0C8, man, np, as, ab, v});
		tick(6);
	endtask : setCfg

	function automatic level_type expLvl(input logic [VAC_W-1:0] v, input level_type p);
		if (v > ((p == LVL_HIGH) ? OFF_RST.point - OFF_RST.hyst : OFF_RST.point)) return LVL_HIGH;
		if (v > ((p != LVL_LOW) ? PRES_RST.point - PRES_RST.hyst : PRES_RST.point)) return LVL_MID;
		return LVL_LOW;
	endfunction : expLvl

	task automatic chkInd(input logic sl, input logic bl, input logic nz, input logic bv);
		#1;
		`CHK({indicators.suctionLed, indicators.blowLed, nozzleOn, blowValve}, {sl, bl, nz, bv})
	endtask : chkInd

	// Flashing red in the middle band is not sampled: its phase depends on a free-running divider
	task automatic setVac(input logic [VAC_W-1:0] v, input logic sk);
		@(posedge ref_clk);
		vacuum <= v;
		curLvl = expLvl(v, curLvl);
		tick(4);
		#1;
		`CHK(indicators.limitOffLed, curLvl == LVL_HIGH)
		`CHK(indicators.limitPresentLed, curLvl != LVL_LOW)
		`CHK(pressureSwitchOut, (curLvl == LVL_HIGH) ^ npnSet)
		`CHK(indicators.statusGreen, sk && curLvl == LVL_HIGH)
		if (curLvl != LVL_MID) `CHK(indicators.statusRed, sk && curLvl == LVL_LOW)
		if (curLvl == LVL_MID) `CHK(indicators.statusRed & ~sk, 1'b0)
	endtask : setVac

	initial begin
		{nrst, regWrite, regRead, suckCmd, blowCmd, npnSet} = '0;
		{regAddr, regWdata, buttonPin, vacuum} = '0;
		curLvl = LVL_LOW;
		void'($urandom(32'h9f79));
		tick(12);
		nrst <= 1'b1;
		rd(OFS_CFG);
		`CHK(rdv, 32'h0000_3205)
		wr(OFS_STAT, 32'hFFFF_FFFF);
		rd(OFS_STAT);
		`CHK(rdv, 32'h0)
		rd(4'h1);
		`CHK(rdv, 32'h0)
		suckCmd <= 1'b1;
		tick(6);
		chkInd(1, 0, 1, 0);
		foreach (corners[i]) setVac(corners[i], 1'b1);
		repeat (24) setVac(VAC_W'($urandom_range(1023, 0)), 1'b1);
		rd(OFS_STAT);
		`CHK(rdv, {18'h0, curLvl, ST_SUCK, vacuum})
		setVac(10'h320, 1'b1);
		setCfg(VAR_NC, 1, 1, 0, 0);
		chkInd(1, 0, 0, 0);
		setVac(10'h259, 1'b1);
		chkInd(1, 0, 0, 0);
		setVac(10'h257, 1'b1);
		chkInd(1, 0, 1, 0);
		// One flash half period later the red phase must have turned over
		redSeen = indicators.statusRed;
		tick(FLASH_HALF_MS * MSC);
		#1;
		`CHK(indicators.statusRed, !redSeen)
		setCfg(VAR_NC, 1, 0, 0, 0);
		suckCmd <= 1'b0;
		tick(6);
		chkInd(0, 1, 0, 1);
		`CHK({indicators.blowDisplay, indicators.statusRed, indicators.statusGreen}, 3'b100)
		tick(190 * MSC);
		chkInd(0, 1, 0, 1);
		tick(14 * MSC);
		chkInd(0, 0, 0, 0);
		blowCmd <= 1'b1;
		tick(6);
		chkInd(0, 1, 0, 1);
		blowCmd <= 1'b0;
		tick(1000);
		setCfg(VAR_IMP, 1, 0, 0, 0);
		suckCmd <= 1'b1;
		tick(4);
		suckCmd <= 1'b0;
		tick(20);
		chkInd(0, 0, 0, 0);
		suckCmd <= 1'b1;
		tick(20);
		suckCmd <= 1'b0;
		tick(6);
		chkInd(1, 0, 1, 0);
		tick(210 * MSC);
		chkInd(1, 0, 1, 0);
		suckCmd <= 1'b1;
		blowCmd <= 1'b1;
		tick(6);
		chkInd(0, 1, 0, 1);
		blowCmd <= 1'b0;
		tick(30);
		chkInd(0, 0, 0, 0);
		suckCmd <= 1'b0;
		tick(6);
		suckCmd <= 1'b1;
		tick(20);
		chkInd(1, 0, 1, 0);
		suckCmd <= 1'b0;
		blowCmd <= 1'b1;
		tick(6);
		blowCmd <= 1'b0;
		tick(10);
		setCfg(VAR_NO, 0, 0, 0, 0);
		chkInd(0, 0, 1, 0);
		suckCmd <= 1'b1;
		tick(6);
		chkInd(1, 0, 0, 0);
		blowCmd <= 1'b1;
		tick(6);
		chkInd(1, 1, 0, 1);
		blowCmd <= 1'b0;
		suckCmd <= 1'b0;
		tick(10);
		setCfg(VAR_NC, 0, 0, 1, 0);
		chkInd(0, 0, 0, 0);
		suckCmd <= 1'b1;
		tick(6);
		chkInd(1, 0, 1, 0);
		setVac(10'h320, 1'b1);
		setVac(10'h000, 1'b1);
		suckCmd <= 1'b0;
		tick(6);
		setCfg(VAR_NC, 0, 0, 0, 1);
		suckCmd <= 1'b1;
		tick(6);
		chkInd(0, 0, 0, 0);
		suckCmd <= 1'b0;
		@(posedge ref_clk);
		buttonPin <= 4'h1;
		tick(3);
		buttonPin <= 4'h0;
		tick(6);
		chkInd(1, 0, 1, 0);
		@(posedge ref_clk);
		buttonPin <= 4'h2;
		tick(3);
		buttonPin <= 4'h0;
		tick(6);
		chkInd(0, 0, 0, 0);
		@(posedge ref_clk);
		buttonPin <= 4'h4;
		tick(6);
		chkInd(0, 1, 0, 1);
		@(posedge ref_clk);
		buttonPin <= 4'h0;
		tick(6);
		// Sinking polarity and manual mode must not survive a reset
		wr(OFS_CFG, 32'h0000_3231);
		nrst <= 1'b0;
		tick(3);
		nrst <= 1'b1;
		rd(OFS_CFG);
		`CHK(rdv, 32'h0000_3205)
		suckCmd <= 1'b1;
		tick(6);
		chkInd(1, 0, 1, 0);
		print_verdict();
	end
endmodule : vacuum_ejector_control_status_tb
`default_nettype wire
